// [inc/sensor_regs_pkg.sv]
// Register map, field layouts and constants of the sensor control block.
// Assumes a 32-bit APB slave in which each 8-bit register takes one word.
package sensor_regs_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_ROW_START_HI = 6'h00;
  localparam logic [5:0] IDX_ROW_START_LO = 6'h01;
  localparam logic [5:0] IDX_COL_START = 6'h02;
  localparam logic [5:0] IDX_ROW_END_HI = 6'h03;
  localparam logic [5:0] IDX_ROW_END_LO = 6'h04;
  localparam logic [5:0] IDX_COL_END = 6'h05;
  localparam logic [5:0] IDX_CAPTURE_CMD = 6'h08;
  localparam logic [5:0] IDX_SENSOR_CTRL = 6'h09;
  localparam logic [5:0] IDX_OUT_PORT = 6'h0a;
  localparam logic [5:0] IDX_CAPTURE_STATUS = 6'h0b;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic idle;
    logic rsvd;
    logic finger_detect_enable;
    logic auto_advance_enable;
    logic osc_source_select;
    logic enable;
  } sensor_control_t;

  typedef struct packed {
    logic [2:0] out1_toggle_rate;
    logic [2:0] out0_toggle_rate;
    logic out1_level;
    logic out0_level;
  } output_port_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic analog_input_select;
    logic fetch_window;
    logic fetch_frame;
    logic fetch_line;
  } capture_cmd_t;

  typedef enum {CAP_IDLE, CAP_RUN} cap_state_t;

  // ----------------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] SC_LOW_RESET = 4'h0;
  localparam output_port_t OUT_PORT_RESET = 8'h00;
  localparam capture_cmd_t CAP_STATUS_RESET = 8'h00;
  localparam logic [2:0] RATE_LEVEL = 3'h0;
  localparam logic [2:0] RATE_SLOWEST = 3'h1;
  localparam logic [2:0] RATE_FASTEST = 3'h4;
  localparam int DIV_LOG2_DEFAULT = 24;
  localparam int DIV_CNT_W = 24;
  localparam logic [8:0] FRAME_LAST_ROW = 9'h12b;
  localparam logic [7:0] LAST_COL = 8'hff;
  localparam logic [1:0] MODE_USB = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : sensor_regs_pkg

// [design/toggle_out.sv]
// One general output pin: static level or divided-clock square wave.
// Assumes the rate and level inputs come straight from the register file.
module toggle_out
  import sensor_regs_pkg::*;
#(
  parameter int SLOW_LOG2 = DIV_LOG2_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] rate,
  input wire logic level,
  output logic pin_q
);

  logic [DIV_CNT_W-1:0] cnt_q;
  logic [2:0] rate_q;
  int tap;

  // Restarting the count on a rate change keeps the first half period full.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      rate_q <= RATE_LEVEL;
    end
    else
    begin
      rate_q <= rate;
      cnt_q <= (rate != rate_q) ? '0 : cnt_q + 1'b1; // R20
    end
  end

  always_comb
  begin
    tap = SLOW_LOG2 - int'(rate);
  end

  // Reserved rate codes hold the pin low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else if (rate == RATE_LEVEL)
      pin_q <= level; // R14 R15
    else if (rate > RATE_FASTEST || rate != rate_q)
      pin_q <= 1'b0;
    else
      pin_q <= cnt_q[tap]; // R12 R13 R20
  end

endmodule : toggle_out

// [design/pixel_cursor.sv]
// Row and column cursor of the pixel scan with its region bounds.
// Assumes load and step never arrive in the same cycle.
module pixel_cursor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic [8:0] row_init,
  input wire logic [7:0] col_init,
  input wire logic [8:0] row_last,
  input wire logic [7:0] col_last,
  output logic [8:0] row_q,
  output logic [7:0] col_q,
  output logic at_last
);

  logic [7:0] col_first_q;
  logic [7:0] col_last_q;
  logic [8:0] row_last_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      col_first_q <= '0;
      col_last_q <= '0;
      row_last_q <= '0;
    end
    else if (load)
    begin
      col_first_q <= col_init;
      col_last_q <= col_last;
      row_last_q <= row_last;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_q <= '0;
      col_q <= '0;
    end
    else if (load)
    begin
      row_q <= row_init;
      col_q <= col_init;
    end
    else if (step)
    begin
      if (col_q == col_last_q)
      begin
        col_q <= col_first_q;
        row_q <= row_q + 9'h001; // R09
      end
      else
        col_q <= col_q + 8'h01; // R09
    end
  end

  assign at_last = (col_q == col_last_q) && (row_q == row_last_q);

endmodule : pixel_cursor

// [design/sensor_control_status_regs.sv]
// Control and status registers of the fingerprint sensor behind APB.
// Assumes an external converter answering adc_start with adc_done, and
// an external interrupt block that applies its own enables and masks.
//
// Local design decision: register access over APB.

// ------------------------------------------------------------------------
// Overview of operation
// ------------------------------------------------------------------------
// Overview of operation
// R01 - Reset clears sensor control bits 4 to 0: chip disabled, oscillator off.
// R02 - Reset loads bits 7:6 from strap pins and bit 5 reads one; code resets bits 7:6 to 00 and takes the straps on the first clock after reset.
// R03 - Bits 7:6 always show strap pins; writes to them are ignored.
// R04 - Bit 5 is read-only: 0 while converting, 1 when converter idle.
// R05 - Bit 3 enables finger detection; in USB mode report on endpoint 2.
// R06 - In CPU or SPI mode finger detection raises the finger interrupt.
// R07 - Finger detection keeps working while the main enable bit is zero.
// R08 - Auto-advance off: result read keeps addresses and starts no conversion.
// R09 - Auto-advance on: read steps column, starts conversion; row steps after.
// R10 - Bit 1 picks crystal or internal oscillator; no function in USB mode.
// R11 - Bit 0 low powers everything down; high enables array, clock, converter.
// R12 - Output 1 rate: 000 level, 001 to 100 clock over 2^24..2^21.
// R13 - Output 0 rate uses the same decode as output 1.
// R14 - With output 1 rate 000, its level bit drives output pin 1.
// R15 - With output 0 rate 000, its level bit drives output pin 0.
// R16 - Capture status is read-only, shadows capture command; bits 7:4 zero.
// R17 - Status bit 3 follows the analog input select command bit.
// R18 - Status bits 2:0 set by fetch commands, cleared after last pixel read.
// R19 - Writing any fetch command bit abandons capture and restarts the region; code restarts only when exactly one fetch bit is written.
// R20 - Square waves come from the logic clock, 50 percent, restart on change.
module sensor_control_status_regs
  import sensor_regs_pkg::*;
#(
  parameter int DIV_LOG2_MAX = DIV_LOG2_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] mode_strap,
  input wire logic finger_sense,
  input wire logic adc_done,
  input wire logic [7:0] adc_result,
  output logic adc_start,
  output logic adc_analog_input,
  output logic [8:0] pixel_row,
  output logic [7:0] pixel_col,
  output logic power_enable,
  output logic osc_source_select,
  output logic finger_detect_enable,
  output logic finger_irq,
  output logic usb_ep2_report,
  output logic out0_pin,
  output logic out1_pin
);

  // ----------------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic mapped;
  logic [5:0] idx;
  logic [31:0] rdata_d;

  assign idx = paddr[7:2];
  assign access = psel & penable;
  assign wr_fire = access & pready_q & pwrite;
  assign rd_fire = access & pready_q & ~pwrite;

  // One wait state: data is looked up, then handed over with pready.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RDATA_ZERO;
    end
    else
    begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access & ~pready_q & ~pwrite)
        prdata_q <= rdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  sensor_control_t sc_q;
  output_port_t port_q;
  capture_cmd_t status_q;
  logic [8:0] row_start_q;
  logic [7:0] col_start_q;
  logic [8:0] row_end_q;
  logic [7:0] col_end_q;
  logic [7:0] result_q;
  logic busy_q;
  logic usb_mode;
  capture_cmd_t wcmd;

  assign wcmd = pwdata[7:0];
  assign usb_mode = (sc_q.mode == MODE_USB);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sc_q.enable <= SC_LOW_RESET[0]; // R01
      sc_q.osc_source_select <= SC_LOW_RESET[1]; // R01
      sc_q.auto_advance_enable <= SC_LOW_RESET[2]; // R01
      sc_q.finger_detect_enable <= SC_LOW_RESET[3]; // R01
      sc_q.rsvd <= 1'b0;
      sc_q.idle <= 1'b1; // R02
      sc_q.mode <= 2'h0;
    end
    else
    begin
      sc_q.mode <= mode_strap; // R02 R03
      sc_q.idle <= ~busy_q; // R04
      if (wr_fire && idx == IDX_SENSOR_CTRL)
      begin
        sc_q.enable <= pwdata[0]; // R11
        sc_q.osc_source_select <= pwdata[1]; // R10
        sc_q.auto_advance_enable <= pwdata[2];
        sc_q.finger_detect_enable <= pwdata[3]; // R05
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_q <= OUT_PORT_RESET;
    else if (wr_fire && idx == IDX_OUT_PORT)
      port_q <= pwdata[7:0];
  end

  // Only bit 0 of each high address byte is kept.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_start_q <= '0;
      col_start_q <= '0;
      row_end_q <= '0;
      col_end_q <= '0;
    end
    else if (wr_fire)
    begin
      case (idx)
        IDX_ROW_START_HI: row_start_q[8] <= pwdata[0];
        IDX_ROW_START_LO: row_start_q[7:0] <= pwdata[7:0];
        IDX_COL_START: col_start_q <= pwdata[7:0];
        IDX_ROW_END_HI: row_end_q[8] <= pwdata[0];
        IDX_ROW_END_LO: row_end_q[7:0] <= pwdata[7:0];
        IDX_COL_END: col_end_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_d = RDATA_ZERO;
    mapped = 1'b1;
    case (idx)
      IDX_ROW_START_HI: rdata_d[0] = row_start_q[8];
      IDX_ROW_START_LO: rdata_d[7:0] = row_start_q[7:0];
      IDX_COL_START: rdata_d[7:0] = col_start_q;
      IDX_ROW_END_HI: rdata_d[0] = row_end_q[8];
      IDX_ROW_END_LO: rdata_d[7:0] = row_end_q[7:0];
      IDX_COL_END: rdata_d[7:0] = col_end_q;
      IDX_CAPTURE_CMD: rdata_d[7:0] = result_q;
      IDX_SENSOR_CTRL: rdata_d[7:0] = sc_q; // R03 R04
      IDX_OUT_PORT: rdata_d[7:0] = port_q;
      IDX_CAPTURE_STATUS: rdata_d[3:0] = status_q[3:0]; // R16
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------------
  cap_state_t state_q;
  logic cmd_wr;
  logic cmd_rd;
  logic start;
  logic advance;
  logic finish;
  logic at_last;
  logic [8:0] row_init;
  logic [7:0] col_init;
  logic [8:0] row_last;
  logic [7:0] col_last;

  assign cmd_wr = wr_fire && idx == IDX_CAPTURE_CMD;
  assign cmd_rd = rd_fire && idx == IDX_CAPTURE_CMD;
  // Two or more fetch bits at once start nothing.
  assign start = cmd_wr && $onehot(wcmd[2:0]); // R19
  assign finish = cmd_rd && state_q == CAP_RUN && at_last;
  assign advance = cmd_rd && state_q == CAP_RUN && !at_last
    && sc_q.auto_advance_enable; // R08 R09

  always_comb
  begin
    row_init = row_start_q;
    col_init = 8'h00;
    row_last = row_start_q;
    col_last = LAST_COL;
    if (wcmd.fetch_frame)
    begin
      row_init = 9'h000;
      row_last = FRAME_LAST_ROW;
    end
    else if (wcmd.fetch_window)
    begin
      col_init = col_start_q;
      row_last = row_end_q;
      col_last = col_end_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= CAP_IDLE;
    else
    begin
      case (state_q)
        CAP_IDLE: if (start) state_q <= CAP_RUN;
        CAP_RUN: if (finish && !start) state_q <= CAP_IDLE; // R18
        default: state_q <= CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= CAP_STATUS_RESET;
    else
    begin
      if (cmd_wr)
        status_q.analog_input_select <= wcmd.analog_input_select; // R17
      if (start)
        status_q[2:0] <= wcmd[2:0]; // R18 R19
      else if (finish)
        status_q[2:0] <= 3'h0; // R18
    end
  end

  pixel_cursor u_cursor (
    .pclk(pclk),
    .presetn(presetn),
    .load(start),
    .step(advance),
    .row_init(row_init),
    .col_init(col_init),
    .row_last(row_last),
    .col_last(col_last),
    .row_q(pixel_row),
    .col_q(pixel_col),
    .at_last(at_last)
  );

  // ----------------------------------------------------------------------
  // Converter handshake
  // ----------------------------------------------------------------------
  logic adc_start_q;

  // A powered-down converter is never started.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_start_q <= 1'b0;
      busy_q <= 1'b0;
      result_q <= 8'h00;
    end
    else
    begin
      adc_start_q <= (start | advance) & sc_q.enable; // R09 R11
      if ((start | advance) & sc_q.enable)
        busy_q <= 1'b1; // R04
      else if (adc_done | ~sc_q.enable)
        busy_q <= 1'b0; // R04
      if (adc_done)
        result_q <= adc_result;
    end
  end

  assign adc_start = adc_start_q;
  assign adc_analog_input = status_q.analog_input_select;
  assign power_enable = sc_q.enable; // R11
  assign finger_detect_enable = sc_q.finger_detect_enable; // R05

  // ----------------------------------------------------------------------
  // Clock select and finger detection
  // ----------------------------------------------------------------------
  logic osc_q;
  logic sense_q;
  logic fd_irq_q;
  logic ep2_q;
  logic fd_event;

  // Detection is not gated by the main enable, so it runs in low power.
  assign fd_event = sc_q.finger_detect_enable & finger_sense & ~sense_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_q <= 1'b0;
      sense_q <= 1'b0;
      fd_irq_q <= 1'b0;
      ep2_q <= 1'b0;
    end
    else
    begin
      osc_q <= sc_q.osc_source_select & ~usb_mode; // R10
      sense_q <= finger_sense;
      fd_irq_q <= fd_event & ~usb_mode; // R06 R07
      ep2_q <= fd_event & usb_mode; // R05 R07
    end
  end

  assign osc_source_select = osc_q;
  assign finger_irq = fd_irq_q;
  assign usb_ep2_report = ep2_q;

  // ----------------------------------------------------------------------
  // General output pins
  // ----------------------------------------------------------------------
  logic [1:0][2:0] rates;
  logic [1:0] levels;
  logic [1:0] pins;

  assign rates = {port_q.out1_toggle_rate, port_q.out0_toggle_rate};
  assign levels = {port_q.out1_level, port_q.out0_level};

  for (genvar i = 0; i < 2; i++)
  begin : g_out
    toggle_out #(.SLOW_LOG2(DIV_LOG2_MAX)) u_out (
      .pclk(pclk),
      .presetn(presetn),
      .rate(rates[i]),
      .level(levels[i]),
      .pin_q(pins[i])
    ); // R12 R13
  end

  assign out0_pin = pins[0];
  assign out1_pin = pins[1];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_strap_follow;
    wr_fire && idx == IDX_SENSOR_CTRL |=> ##1 sc_q.mode == $past(mode_strap);
  endproperty
  a_strap_follow: assert property (p_strap_follow) // R03
    else $error("strap bits do not follow pins");

  property p_idle_flag;
    adc_start_q |-> ##1 !sc_q.idle;
  endproperty
  a_idle_flag: assert property (p_idle_flag) // R04
    else $error("idle bit high during conversion");

  property p_no_advance;
    cmd_rd && !sc_q.auto_advance_enable && !start
      |=> $stable(pixel_col) && $stable(pixel_row) && !adc_start_q;
  endproperty
  a_no_advance: assert property (p_no_advance) // R08
    else $error("read moved cursor without auto advance");

  property p_advance;
    advance && sc_q.enable |=> adc_start_q
      && {pixel_row, pixel_col} != $past({pixel_row, pixel_col});
  endproperty
  a_advance: assert property (p_advance) // R09
    else $error("auto advance did not step and convert");

  property p_out1_level;
    port_q.out1_toggle_rate == RATE_LEVEL
      |=> out1_pin == $past(port_q.out1_level);
  endproperty
  a_out1_level: assert property (p_out1_level) // R14
    else $error("output 1 does not follow its level bit");

  property p_out0_level;
    port_q.out0_toggle_rate == RATE_LEVEL
      |=> out0_pin == $past(port_q.out0_level);
  endproperty
  a_out0_level: assert property (p_out0_level) // R15
    else $error("output 0 does not follow its level bit");

  property p_status_upper;
    access && !pready_q && !pwrite && idx == IDX_CAPTURE_STATUS
      |=> prdata_q[31:4] == 28'h0000000;
  endproperty
  a_status_upper: assert property (p_status_upper) // R16
    else $error("capture status upper bits not zero");

  property p_finish_clear;
    finish && !start |=> status_q[2:0] == 3'h0 && state_q == CAP_IDLE;
  endproperty
  a_finish_clear: assert property (p_finish_clear) // R18
    else $error("fetch status not cleared after last pixel");

  property p_restart;
    start |=> status_q[2:0] == $past(wcmd[2:0]) && state_q == CAP_RUN
      && pixel_row == $past(row_init) && pixel_col == $past(col_init);
  endproperty
  a_restart: assert property (p_restart) // R19
    else $error("fetch command did not restart the region");

  property p_finger_low_power;
    fd_event && !sc_q.enable && !usb_mode |=> finger_irq;
  endproperty
  a_finger_low_power: assert property (p_finger_low_power) // R07
    else $error("finger detect lost in low power");

endmodule : sensor_control_status_regs

// [verification/adc_model.sv]
// Converter model standing on the far side of the start/done handshake.
// Assumes the bench sets latency and the next byte before each start.
module adc_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic [3:0] latency,
  input wire logic [7:0] next_result,
  output logic adc_done,
  output logic [7:0] adc_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wait_q;
  // Outside the done pulse the byte toggles every cycle, so a stale value
  // is never mistaken for a result.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_q <= 5'h00;
      adc_done <= 1'b0;
      adc_result <= 8'h00;
    end
    else
    begin
      adc_done <= (wait_q == 5'h01);
      adc_result <= (wait_q == 5'h01) ? next_result : ~adc_result;
      if (adc_start)
        wait_q <= {1'b0, latency} + 5'h01;
      else if (wait_q != 5'h00)
        wait_q <= wait_q - 5'h01;
    end
endmodule : adc_model

// [verification/testbench.sv]
// Self-checking bench of the sensor control and status registers.
// Assumes the converter model is compiled before this file.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sensor_regs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rnd = 8'h49, nxt = 8'h00, e;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, adc_start, adc_ain, pwr_en, osc_sel, fd_en;
  logic finger_irq, usb_ep2_report, out0_pin, out1_pin, adc_done;
  logic finger_sense = 0;
  logic [1:0] mode_strap = 2'h1, pins;
  logic [3:0] lat = 4'h1;
  logic [7:0] adc_result, pixel_col;
  logic [8:0] pixel_row;
  logic [32:0] exp_q[$], exp_w;
  int fails = 0, tests_run = 0, starts = 0, irqs = 0, reps = 0, n, s;
  assign pins = {out1_pin, out0_pin};
  always #5 pclk = ~pclk;

  sensor_control_status_regs #(.DIV_LOG2_MAX(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_strap(mode_strap),
    .finger_sense(finger_sense), .adc_done(adc_done),
    .adc_result(adc_result), .adc_start(adc_start),
    .adc_analog_input(adc_ain), .pixel_row(pixel_row),
    .pixel_col(pixel_col), .power_enable(pwr_en),
    .osc_source_select(osc_sel), .finger_detect_enable(fd_en),
    .finger_irq(finger_irq), .usb_ep2_report(usb_ep2_report),
    .out0_pin(out0_pin), .out1_pin(out1_pin));
  adc_model conv_far (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
    .latency(lat), .next_result(nxt), .adc_done(adc_done),
    .adc_result(adc_result));

  // ----------------------------------------------------------------------
  // Monitors and bus tasks
  // ----------------------------------------------------------------------
  always @(posedge pclk)
  begin
    starts += (adc_start === 1'b1);
    irqs += (finger_irq === 1'b1);
    reps += (usb_ep2_report === 1'b1);
    if (psel && penable && pready === 1'b1)
    begin
      exp_w = exp_q.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, exp_w)
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    apb(1'b0, {i, 2'b00}, 8'h00, {25'h0, x});
  endtask : rd

  task automatic conv;
    do @(posedge pclk); while (adc_done !== 1'b1);
  endtask : conv

  task automatic half(input int b, output int c);
    logic p;
    c = 0;
    p = pins[b];
    while (pins[b] === p)
      @(posedge pclk);
    p = pins[b];
    while (pins[b] === p)
    begin
      @(posedge pclk);
      c++;
    end
  endtask : half

  task automatic complete_run;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    #400000;
    fails++;
    complete_run();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SENSOR_CTRL, 8'h60);
    rd(IDX_OUT_PORT, 8'h00);
    rd(IDX_CAPTURE_STATUS, 8'h00);
    apb(1'b0, 8'h18, 8'h00, {1'b1, 32'h0});
    apb(1'b1, 8'h3c, 8'hff, {1'b1, 32'h0});
    `CHK(pwr_en, 1'b0)
    $display("test reset done");
    wr(IDX_SENSOR_CTRL, 8'hef);
    rd(IDX_SENSOR_CTRL, 8'h6f);
    `CHK({pwr_en, osc_sel, fd_en}, 3'h7)
    mode_strap <= 2'h2;
    rd(IDX_SENSOR_CTRL, 8'haf);
    `CHK(osc_sel, 1'b0)
    $display("test control done");
    wr(IDX_SENSOR_CTRL, 8'h08);
    for (int m = 0; m < 5; m++)
    begin
      if (m == 4)
        wr(IDX_SENSOR_CTRL, 8'h00);
      mode_strap <= m[1:0];
      @(posedge pclk);
      finger_sense <= 1'b1;
      repeat (3) @(posedge pclk);
      finger_sense <= 1'b0;
      @(posedge pclk);
    end
    `CHK(irqs, 3)
    `CHK(reps, 1)
    $display("test finger done");
    mode_strap <= 2'h1;
    wr(IDX_ROW_START_LO, 8'h05);
    wr(IDX_COL_START, 8'h03);
    wr(IDX_SENSOR_CTRL, 8'h05);
    nxt <= rnd;
    // The status read below takes four cycles, so the first done pulse
    // must come later than that or the wait for it would miss it.
    lat <= 4'h8;
    wr(IDX_CAPTURE_CMD, 8'h01);
    rd(IDX_CAPTURE_STATUS, 8'h01);
    for (int i = 0; i < 256; i++)
    begin
      if (i == 0)
        conv();
      `CHK({pixel_row, pixel_col}, {9'h005, i[7:0]})
      e = nxt;
      rnd = lfsr(rnd);
      nxt <= rnd;
      lat <= rnd[3:0];
      rd(IDX_CAPTURE_CMD, e);
      if (i < 255)
        conv();
    end
    repeat (20) @(posedge pclk);
    rd(IDX_CAPTURE_STATUS, 8'h00);
    $display("test auto capture done");
    wr(IDX_SENSOR_CTRL, 8'h01);
    nxt <= rnd;
    wr(IDX_CAPTURE_CMD, 8'h0a);
    conv();
    rd(IDX_CAPTURE_STATUS, 8'h0a);
    `CHK(adc_ain, 1'b1)
    s = starts;
    rd(IDX_CAPTURE_CMD, rnd);
    rd(IDX_CAPTURE_CMD, rnd);
    repeat (4) @(posedge pclk);
    `CHK(starts, s)
    `CHK({pixel_row, pixel_col}, 17'h0)
    lat <= 4'hf;
    wr(IDX_CAPTURE_CMD, 8'h04);
    repeat (2) @(posedge pclk);
    rd(IDX_SENSOR_CTRL, 8'h41);
    conv();
    `CHK({pixel_row, pixel_col}, {9'h005, 8'h03})
    rd(IDX_SENSOR_CTRL, 8'h61);
    rd(IDX_CAPTURE_STATUS, 8'h04);
    wr(IDX_CAPTURE_CMD, 8'h08);
    rd(IDX_CAPTURE_STATUS, 8'h0c);
    s = starts;
    wr(IDX_CAPTURE_CMD, 8'h03);
    rd(IDX_CAPTURE_STATUS, 8'h04);
    wr(IDX_SENSOR_CTRL, 8'h00);
    wr(IDX_CAPTURE_CMD, 8'h01);
    repeat (4) @(posedge pclk);
    `CHK(starts, s)
    `CHK(pwr_en, 1'b0)
    $display("test manual capture done");
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      wr(IDX_OUT_PORT, {6'h00, rnd[1:0]});
      rd(IDX_OUT_PORT, {6'h00, rnd[1:0]});
      `CHK(pins, rnd[1:0])
    end
    for (int k = 1; k < 5; k++)
    begin
      wr(IDX_OUT_PORT, {k[2:0], k[2:0], 2'b00});
      // Let the old rate's last toggle and the forced low pass first.
      repeat (2) @(posedge pclk);
      half(0, n);
      `CHK(n, 1 << (6 - k))
      half(1, n);
      `CHK(n, 1 << (6 - k))
    end
    wr(IDX_OUT_PORT, 8'hbf);
    repeat (2) @(posedge pclk);
    `CHK(pins, 2'b00)
    $display("test outputs done");
    complete_run();
  end
endmodule : testbench
